// File: text_console_sequence_engine.sv
/*
  Text console sequence engine. Input side turns key codes into
  introducer sequences, optionally widened to 16 bits. Output side parses a
  byte stream into a 25 by 80 character store with rendition attributes.
  Assumes one 100 MHz clock, synchronous active-low reset and an APB master.
*/
`timescale 1ns/100ps
`default_nettype none
module text_console_sequence_engine
  import console_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Key events in and generated characters out.
  input wire logic keyValid,
  input wire logic [4:0] keyCode,
  output logic keyReady,
  output logic inValid,
  output logic [15:0] inChar,
  // Output character stream in.
  input wire logic outValid,
  input wire logic [7:0] outByte,
  output logic outReady
);
  // ********************************************************************
  // Storage and state
  // ********************************************************************
  typedef enum logic [3:0] {
    S_TEXT = 4'b0001, S_CSI = 4'b0010, S_ERASE = 4'b0100, S_FKEY = 4'b1000
  } pstate_t;

  logic [7:0] charMem [CELLS];
  attr_t attrMem [CELLS];
  pstate_t ps_r, ps_nxt;
  logic [4:0] row_r, row_nxt;
  logic [6:0] col_r, col_nxt;
  attr_t attr_r, attr_nxt;
  logic [7:0] p0_r, p0_nxt, p1_r, p1_nxt;
  logic semi_r, semi_nxt;
  logic [10:0] ePtr_r, ePtr_nxt, eEnd_r, eEnd_nxt;
  logic wide_r, wide_nxt;
  logic [2:0] kIdx_r, kIdx_nxt;
  logic [4:0] kCode_r, kCode_nxt;
  logic kBusy_r, kBusy_nxt;
  logic [10:0] sel_r, sel_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic rdy_r, rdy_nxt;
  logic wr;
  logic [7:0] wrChar;
  attr_t wrAttr;
  logic [10:0] wrAddr;
  apb_req_t req;
  logic take;

  // Cell index of a row and column pair.
  function automatic logic [10:0] cellAt(input logic [4:0] r, input logic [6:0] c);
    cellAt = 11'(r * COLS + c);
  endfunction

  // Clamp a signed target into 0..lim-1 so moves never wrap.
  function automatic logic [6:0] clampTo(input int v, input int lim);
    if (v < 0)
      clampTo = 7'h00;
    else if (v >= lim)
      clampTo = 7'(lim - 1);
    else
      clampTo = 7'(v);
  endfunction

  // Last byte of a key sequence; the first is always the introducer.
  function automatic logic [7:0] keyByte(input logic [4:0] k);
    unique case (k)
      5'd0: keyByte = "A";
      5'd1: keyByte = "B";
      5'd2: keyByte = "C";
      5'd3: keyByte = "D";
      5'd4: keyByte = "H";
      5'd5: keyByte = "@";
      5'd6: keyByte = "P";
      5'd7: keyByte = "K";
      5'd8: keyByte = "?";
      5'd9: keyByte = "/";
      5'd10: keyByte = "P";
      5'd11: keyByte = "Q";
      5'd12: keyByte = "w";
      5'd13: keyByte = "x";
      5'd14: keyByte = "t";
      5'd15: keyByte = "u";
      5'd16: keyByte = "q";
      5'd17: keyByte = "r";
      5'd18: keyByte = "p";
      5'd19: keyByte = "M";
      5'd20: keyByte = "A";
      default: keyByte = "B";
    endcase
  endfunction

  assign req = '{psel, penable, pwrite, paddr, pwdata};
  // A byte counts only when offered and accepted, so the host never loses one.
  assign take = outValid && outReady;

  // ********************************************************************
  // Input side: key to sequence generator
  // ********************************************************************
  // Introducer first, then O for function keys, then the identifying letter.
  always_comb begin
    kIdx_nxt = kIdx_r;
    kCode_nxt = kCode_r;
    kBusy_nxt = kBusy_r;
    if (!kBusy_r && keyValid && keyCode < KEY_COUNT) begin
      kBusy_nxt = 1'b1;
      kCode_nxt = keyCode;
      kIdx_nxt = 3'd0;
    end else if (kBusy_r) begin
      if (kIdx_r == 3'd2 || (kIdx_r == 3'd1 && kCode_r < KEY_FIRST_FN))
        kBusy_nxt = 1'b0;
      else if (kIdx_r == 3'd0 && kCode_r < KEY_FIRST_FN)
        kIdx_nxt = 3'd2;
      else
        kIdx_nxt = kIdx_r + 3'd1;
    end
  end

  // Byte chosen for the current step, zero-extended in wide mode.
  logic [7:0] kByte;
  always_comb begin
    kByte = CH_CSI; // [RULE1]
    if (kIdx_r == 3'd1 && kCode_r >= KEY_FIRST_FN)
      kByte = CH_FKEY; // [RULE3]
    else if (kIdx_r != 3'd0)
      kByte = keyByte(kCode_r); // [RULE2] [RULE3]
  end

  // Register key side state and the generated character.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      kIdx_r <= 3'd0;
      kCode_r <= 5'd0;
      kBusy_r <= 1'b0;
      inValid <= 1'b0;
      inChar <= 16'h0000;
      keyReady <= 1'b0;
    end else begin
      kIdx_r <= kIdx_nxt;
      kCode_r <= kCode_nxt;
      kBusy_r <= kBusy_nxt;
      inValid <= kBusy_r;
      // Narrow mode keeps the upper byte zero too, so wide is a pure relabel.
      inChar <= {8'h00, kByte}; // [RULE5] [RULE6]
      keyReady <= !kBusy_nxt;
    end
  end

  // ********************************************************************
  // Output side: stream parser
  // ********************************************************************
  // Erase sequences run one cell per cycle; the stream stalls meanwhile.
  always_comb begin
    int target;
    int dig;
    attr_t a;
    target = 0;
    dig = 0;
    a = attr_r;
    ps_nxt = ps_r;
    row_nxt = row_r;
    col_nxt = col_r;
    attr_nxt = attr_r;
    p0_nxt = p0_r;
    p1_nxt = p1_r;
    semi_nxt = semi_r;
    ePtr_nxt = ePtr_r;
    eEnd_nxt = eEnd_r;
    wr = 1'b0;
    wrChar = CH_BLANK;
    wrAttr = attr_r;
    wrAddr = cellAt(row_r, col_r);
    unique case (ps_r)
      S_ERASE: begin
        wr = 1'b1;
        wrAddr = ePtr_r;
        wrAttr = ATTR_RESET;
        ePtr_nxt = ePtr_r + 11'd1;
        if (ePtr_r == eEnd_r)
          ps_nxt = S_TEXT;
      end
      S_FKEY: begin
        // Function key letters after introducer O carry no screen action.
        if (take)
          ps_nxt = S_TEXT;
      end
      S_CSI: begin
        if (take) begin
          ps_nxt = S_TEXT; // [RULE11]
          if (outByte >= "0" && outByte <= "9") begin
            ps_nxt = S_CSI;
            dig = int'(outByte - "0");
            // Saturate so long digit strings cannot alias to small values.
            if (semi_r)
              p1_nxt = (p1_r > 8'd24) ? PARAM_MAX : 8'(p1_r * 10 + dig); // [RULE23]
            else
              p0_nxt = (p0_r > 8'd24) ? PARAM_MAX : 8'(p0_r * 10 + dig); // [RULE23]
          end else if (outByte == ";") begin
            ps_nxt = S_CSI;
            if (semi_r) begin
              // A third parameter only occurs in rendition lists.
              a = applySgr(attr_r, p0_r);
              attr_nxt = a;
              p0_nxt = p1_r;
              p1_nxt = 8'd0;
            end
            semi_nxt = 1'b1;
          end else if (outByte == "O" && p0_r == 8'd0) begin
            ps_nxt = S_FKEY;
          end else if (outByte == "J" || outByte == "K") begin
            ps_nxt = S_ERASE;
            ePtr_nxt = (outByte == "J") ? cellAt(row_r, col_r) : cellAt(row_r, 7'd0);
            eEnd_nxt = (outByte == "J") ? 11'(CELLS - 1) : cellAt(row_r, 7'(COLS - 1));
            if (p0_r == 8'd0)
              ePtr_nxt = cellAt(row_r, col_r); // [RULE12] [RULE15]
            if (p0_r == 8'd1) begin
              ePtr_nxt = (outByte == "J") ? 11'd0 : cellAt(row_r, 7'd0); // [RULE13] [RULE16]
              eEnd_nxt = cellAt(row_r, col_r);
            end
            if (p0_r == 8'd2) begin
              ePtr_nxt = (outByte == "J") ? 11'd0 : cellAt(row_r, 7'd0); // [RULE14] [RULE17]
              col_nxt = 7'd0;
              if (outByte == "J")
                row_nxt = 5'd0;
            end
            if (p0_r > 8'd2)
              ps_nxt = S_TEXT;
          end else if (outByte == "H") begin
            // Rows and columns count from one; zero or missing means one.
            target = (p0_r == 8'd0) ? 0 : int'(p0_r) - 1;
            row_nxt = 5'(clampTo(target, ROWS)); // [RULE18] [RULE27]
            target = (p1_r == 8'd0) ? 0 : int'(p1_r) - 1;
            col_nxt = clampTo(target, COLS); // [RULE18] [RULE27]
          end else if (outByte >= "A" && outByte <= "D") begin
            dig = (p0_r == 8'd0) ? 1 : int'(p0_r);
            unique case (outByte)
              "A": row_nxt = 5'(clampTo(int'(row_r) - dig, ROWS)); // [RULE19] [RULE27]
              "B": row_nxt = 5'(clampTo(int'(row_r) + dig, ROWS)); // [RULE19] [RULE27]
              "C": col_nxt = clampTo(int'(col_r) + dig, COLS); // [RULE19] [RULE27]
              default: col_nxt = clampTo(int'(col_r) - dig, COLS); // [RULE19] [RULE27]
            endcase
          end else if (outByte == "m") begin
            a = attr_r;
            if (semi_r)
              a = applySgr(a, p0_r); // [RULE20]
            a = applySgr(a, semi_r ? p1_r : p0_r); // [RULE20]
            attr_nxt = a;
          end
        end
      end
      default: begin
        if (take) begin
          p0_nxt = 8'd0;
          p1_nxt = 8'd0;
          semi_nxt = 1'b0;
          if (outByte == CH_CSI) begin
            ps_nxt = S_CSI; // [RULE1] [RULE4] [RULE11]
          end else if (outByte == CH_BS) begin
            if (col_r != 7'd0)
              col_nxt = col_r - 7'd1; // [RULE25]
          end else if (outByte == CH_CR) begin
            col_nxt = 7'd0; // [RULE26]
          end else if (outByte == CH_HT) begin
            // Next stop is the next multiple of eight, never past the margin.
            col_nxt = clampTo(int'(col_r | 7'(TAB_MASK)) + 1, COLS); // [RULE10]
          end else if (outByte == CH_LF || outByte == CH_VT || outByte == CH_FF) begin
            // No scrolling: the bottom line is simply held.
            row_nxt = 5'(clampTo(int'(row_r) + 1, ROWS));
          end else if (outByte >= CH_BLANK && outByByteOk(outByte)) begin
            if (col_r < 7'(COLS)) begin
              wr = 1'b1; // [RULE7] [RULE8]
              wrChar = outByte;
              col_nxt = col_r + 7'd1;
            end // [RULE9]
          end
        end
      end
    endcase
  end

  // Printable codes: everything but C1 controls 7f to 9f.
  function automatic logic outByByteOk(input logic [7:0] b);
    outByByteOk = (b < 8'h7f) || (b > 8'h9f);
  endfunction

  // One rendition parameter folded into the current attributes.
  function automatic attr_t applySgr(input attr_t cur, input logic [7:0] p);
    attr_t n;
    n = cur;
    if (p == 8'd0)
      n = ATTR_RESET; // [RULE21]
    else if (p == 8'd1)
      n.bright = 1'b1; // [RULE21]
    else if (p == 8'd4)
      n.under = 1'b1; // [RULE21]
    else if (p == 8'd7)
      n.reverse = 1'b1; // [RULE21]
    else if (p >= 8'd10 && p <= 8'd19)
      n.font = 4'(p - 8'd10); // [RULE22]
    else if (p >= 8'd30 && p <= 8'd37)
      n.fg = 3'(p - 8'd30); // [RULE24]
    else if (p >= 8'd40 && p <= 8'd47)
      n.bg = 3'(p - 8'd40); // [RULE24]
    applySgr = n;
  endfunction

  // Register parser state and the stream ready output.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ps_r <= S_TEXT;
      row_r <= 5'd0;
      col_r <= 7'd0;
      attr_r <= ATTR_RESET;
      p0_r <= 8'd0;
      p1_r <= 8'd0;
      semi_r <= 1'b0;
      ePtr_r <= 11'd0;
      eEnd_r <= 11'd0;
      outReady <= 1'b0;
    end else begin
      ps_r <= ps_nxt;
      row_r <= row_nxt;
      col_r <= col_nxt;
      attr_r <= attr_nxt;
      p0_r <= p0_nxt;
      p1_r <= p1_nxt;
      semi_r <= semi_nxt;
      ePtr_r <= ePtr_nxt;
      eEnd_r <= eEnd_nxt;
      outReady <= (ps_nxt != S_ERASE);
    end
  end

  // The store has no reset; software clears it with an erase sequence.
  always_ff @(posedge clk) begin
    if (wr && rst_n) begin
      charMem[wrAddr] <= wrChar;
      attrMem[wrAddr] <= wrAttr;
    end
  end

  // ********************************************************************
  // APB slave
  // ********************************************************************
  // Every access answers in its first access cycle; unmapped reads give zero.
  always_comb begin
    wide_nxt = wide_r;
    sel_nxt = sel_r;
    rd_nxt = rd_r;
    rdy_nxt = 1'b0;
    if (req.sel && !req.enable) begin
      rdy_nxt = 1'b1;
      unique case (req.addr)
        ADDR_CTRL: rd_nxt = {31'd0, wide_r};
        ADDR_CURSOR: rd_nxt = {16'd0, 3'd0, row_r, 1'b0, col_r};
        ADDR_ATTR: rd_nxt = {19'd0, attr_r};
        ADDR_CELL_SEL: rd_nxt = {21'd0, sel_r};
        ADDR_CELL_DATA: rd_nxt = {11'd0, attrMem[sel_r], charMem[sel_r]};
        default: rd_nxt = 32'h0000_0000;
      endcase
    end
    if (req.sel && req.enable && pready && req.write) begin
      if (req.addr == ADDR_CTRL)
        wide_nxt = req.wdata[0];
      if (req.addr == ADDR_CELL_SEL)
        sel_nxt = req.wdata[10:0];
    end
  end

  // Register the bus side.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wide_r <= 1'b0;
      sel_r <= 11'd0;
      rd_r <= 32'h0000_0000;
      rdy_r <= 1'b0;
    end else begin
      wide_r <= wide_nxt;
      sel_r <= sel_nxt;
      rd_r <= rd_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  assign prdata = rd_r;
  assign pready = rdy_r;
  assign pslverr = 1'b0;

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // A key is taken, then two edges later the introducer and one edge on the O.
  sequence fkeyTaken;
    keyValid && keyReady && keyCode >= KEY_FIRST_FN && keyCode < KEY_COUNT;
  endsequence
  sequence introThenO;
    ##2 (inValid && inChar == {8'h00, CH_CSI}) ##1 (inValid && inChar == {8'h00, CH_FKEY});
  endsequence
  sequence plainKeyTaken;
    keyValid && keyReady && keyCode < KEY_FIRST_FN;
  endsequence
  sequence introThenLetter;
    ##2 (inValid && inChar == {8'h00, CH_CSI}) ##1 (inValid && inChar != {8'h00, CH_CSI});
  endsequence

  a_key_intro: assert property (plainKeyTaken |-> introThenLetter) else $error("key intro bad"); // [RULE1]
  a_fkey_prefix: assert property (fkeyTaken |-> introThenO) else $error("fkey prefix bad"); // [RULE3]
  a_wide_zero: assert property (inValid |-> inChar[15:8] == 8'h00) else $error("upper byte set"); // [RULE5]
  a_no_wrap: assert property (ps_r == S_TEXT && col_r >= 7'(COLS) |-> !wr) else $error("wrapped"); // [RULE9]
  a_erase_stall: assert property (ps_r == S_ERASE |-> !outReady) else $error("ready in erase"); // [RULE11]
  a_cr_left: assert property (take && ps_r == S_TEXT && outByte == CH_CR |=> col_r == 7'd0) else $error("cr col"); // [RULE26]
  a_row_range: assert property (row_r < 5'(ROWS)) else $error("row outside screen"); // [RULE27]
endmodule // text_console_sequence_engine
`default_nettype wire

// File: console_pkg.sv
/*
  Shared constants and types for the text console sequence engine: character
  codes, key codes, screen geometry, rendition layout and APB register map.
  Assumes a single 100 MHz clock domain and an APB master with 32-bit data.
*/
// Operation
// RULE1 - Every special key sequence starts with introducer byte 9b.
// RULE2 - Arrows encode A,B,C,D; Home/Ins/Del/End/PgUp/PgDn encode H,@,P,K,?,/.
// RULE3 - Function keys 1..12 encode introducer, O, then P Q w x t u q r p M A B.
// RULE4 - The escape-bracket introducer form is neither generated nor recognised.
// RULE5 - Wide mode zero-extends each generated byte to sixteen bits.
// RULE6 - Wide mode passes every printable code 0020 to 007e; here inChar carries only key sequence bytes.
// RULE7 - Latin-1 and box codes b3 to da are stored for display.
// RULE8 - Screen holds 25 lines of 80 character positions.
// RULE9 - Printable character beyond last column is dropped, no wrap.
// RULE10 - Tab stops sit at every eighth column starting at column 9.
// RULE11 - Output stream mixes text and sequences; sequences act, not shown.
// RULE12 - Introducer J or 0J blanks cursor to end of screen.
// RULE13 - Introducer 1J blanks from top-left through the cursor.
// RULE14 - Introducer 2J blanks the screen and homes the cursor.
// RULE15 - Introducer K or 0K blanks cursor to end of line.
// RULE16 - Introducer 1K blanks line start through the cursor.
// RULE17 - Introducer 2K blanks the line and moves cursor to column one.
// RULE18 - Introducer row;col H moves cursor to that row and column.
// RULE19 - Introducer n A/B/C/D moves cursor n up, down, right, left.
// RULE20 - Rendition m applies parameters in order; result governs later text.
// RULE21 - Rendition 0 clears, 1 bright, 4 underscore, 7 reverse.
// RULE22 - Rendition 10 primary font, 11..19 alternate font one to nine.
// RULE23 - Numeric parameters arrive as ASCII digits accumulated into binary.
// RULE24 - Rendition 30..37 foreground and 40..47 background colour.
// RULE25 - Backspace moves left one column, nothing at left margin.
// RULE26 - Carriage return moves cursor to column one of same line.
// RULE27 - Out of range cursor targets clamp to the screen edges.
package console_pkg;
  // ********************************************************************
  // Geometry and codes
  // ********************************************************************
  localparam int ROWS = 25;
  localparam int COLS = 80;
  localparam int CELLS = ROWS * COLS;
  localparam logic [7:0] CH_CSI = 8'h9b;
  localparam logic [7:0] CH_BS = 8'h08;
  localparam logic [7:0] CH_HT = 8'h09;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_VT = 8'h0b;
  localparam logic [7:0] CH_FF = 8'h0c;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_BLANK = 8'h20;
  localparam logic [7:0] CH_FKEY = 8'h4f;
  localparam logic [4:0] TAB_MASK = 5'h07;
  // Key codes on the key input: 0..3 arrows, 4..9 editing keys, 10..21 F1..F12.
  localparam logic [4:0] KEY_COUNT = 5'h16;
  localparam logic [4:0] KEY_FIRST_FN = 5'h0a;
  // ********************************************************************
  // APB map and reset values
  // ********************************************************************
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CURSOR = 12'h004;
  localparam logic [11:0] ADDR_ATTR = 12'h008;
  localparam logic [11:0] ADDR_CELL_SEL = 12'h00c;
  localparam logic [11:0] ADDR_CELL_DATA = 12'h010;
  localparam logic [2:0] FG_RESET = 3'h7;
  localparam logic [2:0] BG_RESET = 3'h0;
  localparam logic [7:0] PARAM_MAX = 8'hff;

  // Rendition state carried with every stored character.
  typedef struct packed {
    logic bright;
    logic under;
    logic reverse;
    logic [3:0] font;
    logic [2:0] fg;
    logic [2:0] bg;
  } attr_t;

  localparam attr_t ATTR_RESET = '{1'b0, 1'b0, 1'b0, 4'h0, FG_RESET, BG_RESET};

  // One APB request as seen by the slave.
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } apb_req_t;
endpackage : console_pkg

// File: host_stream_model.sv
/*
  Host side model: feeds the engine's output byte stream and collects the
  characters that the engine generates. Assumes the bench fills txQ.
*/
`timescale 1ns/100ps
`default_nettype none
module host_stream_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Byte stream towards the engine.
  output logic outValid,
  output logic [7:0] outByte,
  input wire logic outReady,
  // Characters from the engine.
  input wire logic inValid,
  input wire logic [15:0] inChar
);
  logic [7:0] txQ[$];
  logic [15:0] rxQ[$];

  // One byte is held until the engine takes it; text and sequences mix freely.
  initial begin
    outValid = 1'b0;
    outByte = 8'h00;
    forever begin
      @(posedge clk);
      if (inValid === 1'b1) rxQ.push_back(inChar);
      if (outValid && outReady === 1'b1) txQ.delete(0);
      if (rst_n && txQ.size() > 0) begin
        outValid <= 1'b1;
        outByte <= txQ[0];
      end else begin
        outValid <= 1'b0;
        // A released line must not keep showing the last byte.
        outByte <= ~outByte;
      end
    end
  end
endmodule // host_stream_model
`default_nettype wire

// File: testbench.sv
/*
  Self-checking bench for the text console engine: keys, stream and APB.
  Assumes the host model drives the byte stream; a tilde stands for the
  introducer byte in stream strings.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench
  import console_pkg::*;
;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic keyValid, keyReady, inValid, outValid, outReady;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] keyCode;
  logic [15:0] inChar;
  logic [7:0] outByte;
  int nFail = 0;
  int testsRun = 0;
  localparam logic [20:0] BLANK = {ATTR_RESET, CH_BLANK};

  text_console_sequence_engine text_console_sequence_engine_i (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .keyValid(keyValid),
    .keyCode(keyCode), .keyReady(keyReady), .inValid(inValid), .inChar(inChar),
    .outValid(outValid), .outByte(outByte), .outReady(outReady));
  host_stream_model host_stream_model_i (.clk(clk), .rst_n(rst_n), .outValid(outValid),
    .outByte(outByte), .outReady(outReady), .inValid(inValid), .inChar(inChar));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // Compare and count; a mismatch is reported at once.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      nFail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One APB transfer; the request is held until pready is seen at an edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk_cur(input int r, input int c);
    apb(1'b0, ADDR_CURSOR, 32'h0, rd);
    check("cursor", rd, {19'h0, 5'(r), 1'b0, 7'(c)});
  endtask

  task automatic chk_cell(input int idx, input logic [20:0] e);
    apb(1'b1, ADDR_CELL_SEL, 32'(idx), rd);
    apb(1'b0, ADDR_CELL_DATA, 32'h0, rd);
    check("cell", rd, {11'h0, e});
  endtask

  // Queue a byte string, then wait until it is taken and any erase is over.
  task automatic send(input string s);
    int n;
    n = 0;
    for (int i = 0; i < s.len(); i++) host_stream_model_i.txQ.push_back(s[i] == "~" ? CH_CSI : s[i]);
    do @(posedge clk); while (host_stream_model_i.txQ.size() != 0 && ++n < 9000);
    repeat (3) @(posedge clk);
    while (outReady !== 1'b1 && ++n < 9000) @(posedge clk);
    // A stream that never drains is a failure, not a silent skip.
    if (n >= 9000) nFail++;
    repeat (2) @(posedge clk);
  endtask

  // Press one key and compare the generated characters in order.
  task automatic press(input logic [4:0] k, input byte letter);
    logic [15:0] q[$];
    q = {16'h009b};
    if (k >= KEY_FIRST_FN) q.push_back(16'h004f);
    q.push_back({8'h00, letter});
    host_stream_model_i.rxQ.delete();
    @(posedge clk);
    keyValid <= 1'b1;
    keyCode <= k;
    do @(posedge clk); while (keyReady !== 1'b1);
    keyValid <= 1'b0;
    repeat (6) @(posedge clk);
    check("key count", host_stream_model_i.rxQ.size(), q.size());
    foreach (q[i]) check("key char", host_stream_model_i.rxQ[i], q[i]);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    apb(1'b0, ADDR_ATTR, 32'h0, rd);
    check("attr reset", rd, 32'(ATTR_RESET));
    chk_cur(0, 0);
    apb(1'b1, 12'h014, 32'hffff_ffff, rd);
    apb(1'b0, 12'h014, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    // Cursor is read-only, so a write must leave it alone.
    apb(1'b1, ADDR_CURSOR, 32'h0000_0305, rd);
    chk_cur(0, 0);
    check("slave error", {31'h0, pslverr}, 32'h0);
    $display("Test registers done");
  endtask

  task automatic t_keys();
    string keys;
    keys = "ABCDH@PK?/PQwxtuqrpMAB";
    for (int k = 0; k < 22; k++) press(5'(k), keys[k]);
    apb(1'b1, ADDR_CTRL, 32'h1, rd);
    apb(1'b0, ADDR_CTRL, 32'h0, rd);
    check("wide mode", rd, 32'h1);
    press(5'h0b, "Q");
    press(5'h04, "H");
    apb(1'b1, ADDR_CTRL, 32'h0, rd);
    $display("Test keys done");
  endtask

  task automatic t_cursor();
    send("~2J");
    chk_cur(0, 0);
    send("~5;10H");
    chk_cur(4, 9);
    send("~3A");
    chk_cur(1, 9);
    send("~9A");
    chk_cur(0, 9);
    send("~2B~4C~2D");
    chk_cur(2, 11);
    send("~99;99H~30B~200C");
    chk_cur(24, 79);
    send("\015");
    chk_cur(24, 0);
    send("\010");
    chk_cur(24, 0);
    send("\011\011\010");
    chk_cur(24, 15);
    $display("Test cursor done");
  endtask

  task automatic t_text();
    send("~2J~1;79HXYZ~2;1H\263\332\351");
    chk_cell(78, {ATTR_RESET, 8'h58});
    chk_cell(79, {ATTR_RESET, 8'h59});
    chk_cell(80, {ATTR_RESET, 8'hb3});
    chk_cell(81, {ATTR_RESET, 8'hda});
    chk_cell(82, {ATTR_RESET, 8'he9});
    $display("Test text done");
  endtask

  task automatic t_rend();
    send("~3;1H~1;4;7;13;31;42mA~0;10;37;40mB~19;35;44mC");
    chk_cell(160, {3'b111, 4'h3, 3'h1, 3'h2, 8'h41});
    chk_cell(161, {ATTR_RESET, 8'h42});
    chk_cell(162, {3'b000, 4'h9, 3'h5, 3'h4, 8'h43});
    apb(1'b0, ADDR_ATTR, 32'h0, rd);
    check("attr", rd, {19'h0, 3'b000, 4'h9, 3'h5, 3'h4});
    send("~0;10;37;40m");
    $display("Test rendition done");
  endtask

  task automatic t_erase();
    send("~2J~3;1HABCDEF~3;3H~1K");
    chk_cell(162, BLANK);
    chk_cell(163, {ATTR_RESET, 8'h44});
    send("~3;5H~0K");
    chk_cell(165, BLANK);
    chk_cell(163, {ATTR_RESET, 8'h44});
    send("~3;4H~2K");
    chk_cell(163, BLANK);
    chk_cur(2, 0);
    send("~1;1HQ~2;1HR~2;2HS~2;1H~1J");
    chk_cell(80, BLANK);
    chk_cell(81, {ATTR_RESET, 8'h53});
    send("~1;1HQ~1;2H~J");
    chk_cell(0, {ATTR_RESET, 8'h51});
    chk_cell(81, BLANK);
    $display("Test erase done");
  endtask

  // Free-running clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Reset, then the scenarios in turn.
  initial begin
    {rst_n, psel, penable, pwrite, keyValid} = 5'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    keyCode = 5'h00;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_keys();
    t_cursor();
    t_text();
    t_rend();
    t_erase();
    give_verdict();
  end

  // Watchdog: the run needs about nine thousand cycles.
  initial begin
    repeat (60000) @(posedge clk);
    nFail++;
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
